// ===== shared/qhc_pkg.sv
package qhc_pkg;

  // register byte addresses
  localparam logic [7:0] QHC_ADDR_FUNC     = 8'h00;
  localparam logic [7:0] QHC_ADDR_MODE     = 8'h04;
  localparam logic [7:0] QHC_ADDR_COUNT1   = 8'h08;
  localparam logic [7:0] QHC_ADDR_COUNT2   = 8'h0c;
  localparam logic [7:0] QHC_ADDR_TARGET1  = 8'h10;
  localparam logic [7:0] QHC_ADDR_TARGET2  = 8'h14;
  localparam logic [7:0] QHC_ADDR_STATUS   = 8'h18;
  localparam logic [7:0] QHC_ADDR_INPUTS   = 8'h1c;

  // function register layout
  localparam int QHC_FUNC_CNT_LSB  = 0;
  localparam int QHC_FUNC_PME_LSB  = 2;
  localparam int QHC_FUNC_INT_LSB  = 6;
  localparam int QHC_FUNC_W        = 10;

  // status register layout
  localparam int QHC_STAT_HIT_LSB  = 0;
  localparam int QHC_STAT_EVT_LSB  = 2;

  // input map: channel n uses inputs 3+2n (phase a) and 4+2n (phase b), numbered from 1
  localparam int QHC_FIRST_SPECIAL = 2;

  // reset values and accumulator compare values
  localparam logic [31:0] QHC_COUNT_RST  = 32'h0000_0000;
  localparam logic [31:0] QHC_TARGET_RST = 32'h0000_0000;
  localparam logic [2:0]  QHC_ACC_ZERO   = 3'h0;
  localparam logic [2:0]  QHC_ACC_UP     = 3'h3;
  localparam logic [2:0]  QHC_ACC_DOWN   = 3'h5;

  // decode modes, one bit per channel
  typedef enum logic {
    QHC_SIMPLE   = 1'b0,
    QHC_ENHANCED = 1'b1
  } qhc_mode_e;

endpackage

// ===== design/qhc_counter.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] - channel 1 counts on inputs 3/4, channel 2 on inputs 5/6 as phases a/b.
// [RULE2] - each channel counts reliably for pulse rates up to 10 kHz.
// [RULE3] - the encoder drives two trains a quarter period apart; lead sets direction.
// [RULE4] - phase a leading phase b increments the count once per pulse.
// [RULE5] - phase a lagging phase b decrements the count once per pulse.
// [RULE6] - with phase b low, phase a pulses increment the count.
// [RULE7] - with phase a low, phase b pulses decrement the count.
// [RULE8] - count reaching the programmed target raises an event to software.
// [RULE9] - after a match, a new target may be loaded to fire again.
// [RULE10] - enabling a counter also enables pulse measurement on its two inputs.
// [RULE11] - other special functions sharing an input are mutually exclusive.
// [RULE12] - inputs with no special function read as plain on/off inputs.
// [RULE13] - simple mode does not suppress jitter counts; single phase counting works.
// [RULE14] - enhanced mode checks both phases and blocks jitter counts.
// [RULE15] - mode bit 0 selects channel 1, bit 1 channel 2; 1 means enhanced.
// [RULE16] - default resolution changes the count by one per full quadrature cycle.
// [RULE17] - phase inputs pass two flip-flops before any edge or direction logic.
// [RULE18] - each count is a 32-bit signed register, wrapping, cleared by reset.
module qhc_counter
  import qhc_pkg::*;
#(
  parameter int NUM_IN = 8
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic [NUM_IN-1:0] i_din,
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  output logic      [1:0]        o_target_hit,
  output logic      [3:0]        o_pulse_measure_enable,
  output logic      [3:0]        o_input_event,
  output logic      [NUM_IN-1:0] o_plain_in
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_IN-1:0]     sync1;
    logic [NUM_IN-1:0]     sync2;
    logic [NUM_IN-1:0]     prev;
    logic [QHC_FUNC_W-1:0] func;
    logic [1:0]            mode;
    logic [1:0][31:0]      count;
    logic [1:0][2:0]       accum;
    logic [1:0][31:0]      target;
    logic [1:0]            armed;
    logic [1:0]            hit;
    logic [3:0]            evt;
    logic [3:0]            pme;
    logic [NUM_IN-1:0]     plain;
    logic [31:0]           rdata;
  } qhc_state_s;

  qhc_state_s st;
  qhc_state_s next_st;

  // quarter-step of the gray sequence 00->10->11->01 (a leads): +1, reverse: -1
  function automatic logic [1:0] qhc_step(input logic [1:0] was, input logic [1:0] now);
    logic [1:0] r;
    r = 2'b00;
    unique case ({was, now})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'b01;
      4'b1000, 4'b1110, 4'b0111, 4'b0001: r = 2'b11;
      default:                            r = 2'b00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]        cnt_en;
  logic [3:0]        busy;
  logic [NUM_IN-1:0] special;
  logic              a_now;
  logic              b_now;
  logic              a_was;
  logic              b_was;
  logic [1:0]        step;
  logic [31:0]       status;

  always_comb begin
    next_st = st;
    a_now   = 1'b0;
    b_now   = 1'b0;
    a_was   = 1'b0;
    b_was   = 1'b0;
    step    = 2'b00;
    cnt_en  = st.func[QHC_FUNC_CNT_LSB +: 2];
    // only sync2 and later are looked at by decode logic
    next_st.sync1 = i_din;                                              // [RULE17]
    next_st.sync2 = st.sync1;                                           // [RULE17]
    next_st.prev  = st.sync2;

    // counter pairs force pulse measurement; otherwise software picks it
    for (int i = 0; i < 4; i++) begin
      next_st.pme[i] = cnt_en[i/2] | st.func[QHC_FUNC_PME_LSB + i];     // [RULE10]
    end
    // input event function yields to whatever else owns the input
    busy = next_st.pme;                                                 // [RULE11]

    special = '0;
    for (int i = 0; i < 4; i++) begin
      special[QHC_FIRST_SPECIAL + i] = busy[i] | st.func[QHC_FUNC_INT_LSB + i];
    end
    next_st.plain = st.sync2 & ~special;                                // [RULE12]

    for (int i = 0; i < 4; i++) begin
      if (st.func[QHC_FUNC_INT_LSB + i] && !busy[i] &&
          st.sync2[QHC_FIRST_SPECIAL + i] && !st.prev[QHC_FIRST_SPECIAL + i]) begin
        next_st.evt[i] = 1'b1;                                          // [RULE11]
      end
    end

    for (int c = 0; c < 2; c++) begin
      a_now = st.sync2[QHC_FIRST_SPECIAL + 2*c];                        // [RULE1]
      b_now = st.sync2[QHC_FIRST_SPECIAL + 2*c + 1];                    // [RULE1]
      a_was = st.prev[QHC_FIRST_SPECIAL + 2*c];
      b_was = st.prev[QHC_FIRST_SPECIAL + 2*c + 1];
      // every edge is seen at 25 MHz sampling, far above a 10 kHz input
      if (cnt_en[c]) begin                                              // [RULE2]
        if (st.mode[c] == QHC_SIMPLE) begin                             // [RULE15]
          next_st.accum[c] = QHC_ACC_ZERO;
          // one count per a rising edge with b low or b rising edge with a low, no jitter lock-out
          if (a_now && !a_was && !b_now) begin                          // [RULE13]
            next_st.count[c] = st.count[c] + 32'h0000_0001;             // [RULE4] [RULE6]
          end else if (b_now && !b_was && !a_now) begin                 // [RULE13]
            next_st.count[c] = st.count[c] - 32'h0000_0001;             // [RULE5] [RULE7]
          end
        end else begin
          // quarter steps accumulate; jitter back and forth cancels out
          step = qhc_step({a_was, b_was}, {a_now, b_now});              // [RULE14]
          if (step == 2'b01) begin
            if (st.accum[c] == QHC_ACC_UP) begin
              next_st.accum[c] = QHC_ACC_ZERO;
              next_st.count[c] = st.count[c] + 32'h0000_0001;           // [RULE4] [RULE16]
            end else begin
              next_st.accum[c] = st.accum[c] + 3'h1;
            end
          end else if (step == 2'b11) begin
            if (st.accum[c] == QHC_ACC_DOWN) begin
              next_st.accum[c] = QHC_ACC_ZERO;
              next_st.count[c] = st.count[c] - 32'h0000_0001;           // [RULE5] [RULE16]
            end else begin
              next_st.accum[c] = st.accum[c] - 3'h1;
            end
          end
        end
      end else begin
        next_st.accum[c] = QHC_ACC_ZERO;
      end

      // one event per armed target; reloading the target re-arms
      if (st.armed[c] && st.count[c] == st.target[c]) begin
        next_st.hit[c]   = 1'b1;                                        // [RULE8]
        next_st.armed[c] = 1'b0;                                        // [RULE9]
      end
    end

    status = '0;
    status[QHC_STAT_HIT_LSB +: 2] = st.hit;
    status[QHC_STAT_EVT_LSB +: 4] = st.evt;

    ////////////////////////////////////////////////////////////////////////
    if (i_wr) begin
      unique case (i_addr)
        QHC_ADDR_FUNC:    next_st.func = i_wdata[QHC_FUNC_W-1:0];
        QHC_ADDR_MODE:    next_st.mode = i_wdata[1:0];                  // [RULE15]
        QHC_ADDR_COUNT1:  next_st.count[0] = i_wdata;
        QHC_ADDR_COUNT2:  next_st.count[1] = i_wdata;
        QHC_ADDR_TARGET1: begin
          next_st.target[0] = i_wdata;                                  // [RULE9]
          next_st.armed[0]  = 1'b1;
        end
        QHC_ADDR_TARGET2: begin
          next_st.target[1] = i_wdata;                                  // [RULE9]
          next_st.armed[1]  = 1'b1;
        end
        // write one to clear; a flag set in this same cycle survives
        QHC_ADDR_STATUS: begin
          next_st.hit = (st.hit & ~i_wdata[QHC_STAT_HIT_LSB +: 2]) | (next_st.hit & ~st.hit);
          next_st.evt = (st.evt & ~i_wdata[QHC_STAT_EVT_LSB +: 4]) | (next_st.evt & ~st.evt);
        end
        default: ;
      endcase
    end

    next_st.rdata = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        QHC_ADDR_FUNC:    next_st.rdata = {{(32-QHC_FUNC_W){1'b0}}, st.func};
        QHC_ADDR_MODE:    next_st.rdata = {30'h0000_0000, st.mode};
        QHC_ADDR_COUNT1:  next_st.rdata = st.count[0];
        QHC_ADDR_COUNT2:  next_st.rdata = st.count[1];
        QHC_ADDR_TARGET1: next_st.rdata = st.target[0];
        QHC_ADDR_TARGET2: next_st.rdata = st.target[1];
        QHC_ADDR_STATUS:  next_st.rdata = status;
        QHC_ADDR_INPUTS:  next_st.rdata = {{(32-NUM_IN){1'b0}}, st.sync2};
        default:          next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st <= '0;
      st.count[0]  <= QHC_COUNT_RST;                                    // [RULE18]
      st.count[1]  <= QHC_COUNT_RST;                                    // [RULE18]
      st.target[0] <= QHC_TARGET_RST;
      st.target[1] <= QHC_TARGET_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata                = st.rdata;
  assign o_target_hit           = st.hit;
  assign o_pulse_measure_enable = st.pme;
  assign o_input_event          = st.evt;
  assign o_plain_in             = st.plain;

endmodule

// ===== dv/qhc_encoder_model.sv
`timescale 1ns/1ps
module qhc_encoder_model #(
  parameter int QTR = 5
) (
  input  wire logic i_ref_clk,
  output logic      o_pha,
  output logic      o_phb
);
  initial begin
    o_pha = 1'b0;
    o_phb = 1'b0;
  end
  task automatic quarter(input logic a, input logic b);
    @(posedge i_ref_clk);
    o_pha <= a;
    o_phb <= b;
    repeat (QTR - 1) @(posedge i_ref_clk);
  endtask
  // forward: a leads b by a quarter period; reverse: b leads a
  task automatic turn(input logic fwd);
    quarter(fwd, !fwd);
    quarter(1'b1, 1'b1);
    quarter(!fwd, fwd);
    quarter(1'b0, 1'b0);
  endtask
  // single phase pulses, other held low; doubles as a jiggle on one edge
  task automatic tap(input logic on_a, input int n);
    repeat (n) begin
      quarter(on_a, !on_a);
      quarter(1'b0, 1'b0);
    end
  endtask
endmodule

// ===== dv/qhc_counter_props.sv
`timescale 1ns/1ps
module qhc_counter_props
  import qhc_pkg::*;
#(
  parameter int NUM_IN = 8
) (
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire logic [NUM_IN-1:0] i_din,
  input wire logic [7:0]        i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  input wire logic [1:0]        o_target_hit,
  input wire logic [3:0]        o_pulse_measure_enable,
  input wire logic [3:0]        o_input_event,
  input wire logic [NUM_IN-1:0] o_plain_in
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_func_on; i_wr && i_addr == QHC_ADDR_FUNC && i_wdata[0]; endsequence
  sequence s_quiet_rise; !i_din[0] [*3] ##1 i_din[0]; endsequence
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (i_rd && i_addr == 8'h20 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_PME_ON: assert property (s_func_on |-> ##[1:2] o_pulse_measure_enable[1:0] == 2'b11)
    else $error("counter enable did not enable pulse measure");
  AST_MASK: assert property (o_pulse_measure_enable[0] && $past(o_pulse_measure_enable[0])
    |-> !o_plain_in[2]) else $error("special input shown as plain");
  AST_PLAIN: assert property (i_din[0] [*4] |=> o_plain_in[0])
    else $error("plain input not passed");
  AST_SYNC: assert property (s_quiet_rise |-> !o_plain_in[0] ##1 !o_plain_in[0])
    else $error("input reached output with too few stages");
  AST_HIT_STICKY: assert property (o_target_hit[0] && !(i_wr && i_addr == QHC_ADDR_STATUS)
    |=> o_target_hit[0]) else $error("target hit flag lost");
  AST_HIT_CLR: assert property (i_wr && i_addr == QHC_ADDR_STATUS && i_wdata[0] && o_target_hit[0]
    |=> !o_target_hit[0]) else $error("target hit flag not cleared");
endmodule
bind qhc_counter qhc_counter_props #(.NUM_IN(NUM_IN)) i_qhc_counter_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_din(i_din), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_target_hit(o_target_hit),
  .o_pulse_measure_enable(o_pulse_measure_enable), .o_input_event(o_input_event),
  .o_plain_in(o_plain_in));

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  import qhc_pkg::*;
  logic        i_ref_clk, i_rst_n, i_wr, i_rd, a1, b1, a2, b2;
  logic [7:0]  i_addr, o_plain_in;
  logic [31:0] i_wdata, o_rdata;
  logic [1:0]  o_target_hit, din_lo, din_hi;
  logic [3:0]  o_pulse_measure_enable, o_input_event;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  qhc_encoder_model i_enc1 (.i_ref_clk(i_ref_clk), .o_pha(a1), .o_phb(b1));
  qhc_encoder_model i_enc2 (.i_ref_clk(i_ref_clk), .o_pha(a2), .o_phb(b2));
  qhc_counter #(.NUM_IN(8)) i_qhc_counter (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_din({din_hi, b2, a2, b1, a1, din_lo}), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_target_hit(o_target_hit),
    .o_pulse_measure_enable(o_pulse_measure_enable), .o_input_event(o_input_event),
    .o_plain_in(o_plain_in));
  task automatic wrap_up;
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    cmp(o_rdata, exp);
  endtask
  // a hang in the encoder tasks must still end in the verdict
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, din_lo, din_hi} = {3'h0, 8'h00, 32'h0, 2'h1, 2'h2};
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd_chk(QHC_ADDR_COUNT1, 32'h0);
    wr(QHC_ADDR_FUNC, 32'h3);
    repeat (2) @(negedge i_ref_clk);
    cmp({28'h0, o_pulse_measure_enable}, 32'hf);
    cmp({24'h0, o_plain_in}, 32'h81);
    repeat (3) i_enc1.turn(1'b1);
    rd_chk(QHC_ADDR_COUNT1, 32'h3);
    repeat (2) i_enc1.turn(1'b0);
    rd_chk(QHC_ADDR_COUNT1, 32'h1);
    i_enc1.tap(1'b1, 2);
    rd_chk(QHC_ADDR_COUNT1, 32'h3);
    i_enc1.tap(1'b0, 3);
    rd_chk(QHC_ADDR_COUNT1, 32'h0);
    rd_chk(QHC_ADDR_COUNT2, 32'h0);
    // a jiggle counts in simple mode and is locked out in enhanced mode
    for (int m = 0; m < 4; m++) begin
      wr(QHC_ADDR_MODE, 32'(m));
      fork
        i_enc1.tap(1'b1, 2);
        i_enc2.tap(1'b1, 2);
      join
      rd_chk(QHC_ADDR_COUNT1, m[0] ? 32'h0 : 32'h2);
      rd_chk(QHC_ADDR_COUNT2, m[1] ? 32'h0 : 32'h2);
      wr(QHC_ADDR_COUNT1, 32'h0);
      wr(QHC_ADDR_COUNT2, 32'h0);
    end
    fork
      i_enc1.turn(1'b1);
      i_enc2.turn(1'b0);
    join
    rd_chk(QHC_ADDR_COUNT1, 32'h1);
    rd_chk(QHC_ADDR_COUNT2, 32'hffff_ffff);
    wr(QHC_ADDR_TARGET1, 32'h3);
    i_enc1.turn(1'b1);
    cmp({30'h0, o_target_hit}, 32'h0);
    i_enc1.turn(1'b1);
    rd_chk(QHC_ADDR_STATUS, 32'h1);
    wr(QHC_ADDR_STATUS, 32'h1);
    wr(QHC_ADDR_TARGET1, 32'h4);
    @(negedge i_ref_clk);
    cmp({30'h0, o_target_hit}, 32'h0);
    i_enc1.turn(1'b1);
    @(negedge i_ref_clk);
    cmp({30'h0, o_target_hit}, 32'h1);
    wr(QHC_ADDR_COUNT2, 32'h7fff_ffff);
    i_enc2.turn(1'b1);
    rd_chk(QHC_ADDR_COUNT2, 32'h8000_0000);
    rd_chk(8'h20, 32'h0);
    din_lo <= 2'h0;
    repeat (4) @(posedge i_ref_clk);
    din_lo <= 2'h1;
    repeat (5) @(posedge i_ref_clk);
    // ch2 counting, events on inputs 3 and 5; input 5 is owned by the counter
    wr(QHC_ADDR_FUNC, 32'h142);
    i_enc1.tap(1'b1, 1);
    @(negedge i_ref_clk);
    cmp({28'h0, o_input_event}, 32'h1);
    wr(QHC_ADDR_STATUS, 32'h4);
    @(negedge i_ref_clk);
    cmp({28'h0, o_input_event}, 32'h0);
    din_hi <= 2'h1;
    repeat (5) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    cmp({24'h0, o_plain_in}, 32'h41);
    wrap_up();
  end
endmodule
